/* File: shared/rsm_pkg.sv */
// Purpose: Shared constants, types and helpers of the rotate/shift/mask unit.
// Assumes: 32-bit data, 5-bit byte address on a classic Wishbone slave.
// Notes: Vectors are little-endian; big-endian bit i is vector bit 31-i.
package rsm_pkg;

    // ==========================================================
    // Widths and register offsets
    localparam int DW = 32;
    localparam int AW = 5;
    localparam int CW = 5;
    localparam logic [AW-1:0] OFF_SRC = 5'h00;
    localparam logic [AW-1:0] OFF_AMT = 5'h04;
    localparam logic [AW-1:0] OFF_DEST = 5'h08;
    localparam logic [AW-1:0] OFF_CTRL = 5'h0c;
    localparam logic [AW-1:0] OFF_COND = 5'h10;
    localparam logic [AW-1:0] OFF_EXC = 5'h14;
    localparam logic [AW-1:0] OFF_INSN = 5'h18;
    localparam logic [3:0] SEL_ALL = 4'hf;
    localparam logic [DW-1:0] ONES = 32'hffffffff;
    localparam logic [DW-1:0] ZERO = 32'h00000000;

    // ==========================================================
    // Field positions
    localparam int AMT_BIG = 5;     // Count of 32 or more
    localparam int EXC_SO = 31; // Summary overflow
    localparam int EXC_BORROW = 29; // Shift borrow
    localparam int COND_LESS = 3;
    localparam int COND_GREATER = 2;
    localparam int COND_EQUAL = 1;
    localparam int COND_SO = 0;
    localparam int INSN_PRI_LSB = 26;
    localparam int INSN_EXT_LSB = 1;
    localparam int INSN_RECORD = 0;
    localparam logic [5:0] PRI_SRA = 6'h1f;
    localparam logic [9:0] EXT_SRA = 10'h318;

    // ==========================================================
    // Operations and control word
    typedef enum logic [2:0] {
        OP_INSERT,
        OP_AND_IMM,
        OP_AND_REG,
        OP_SHL,
        OP_SRA
    } op_t;

    typedef struct packed {
        logic [11:0] rsvd;
        logic rot_right;
        logic record_flag;
        logic [CW-1:0] mask_end;
        logic [CW-1:0] mask_begin;
        logic [CW-1:0] rotate_amount;
        logic [2:0] op;
    } ctrl_t;

    // Circular left rotate
    function automatic logic [DW-1:0] rotl(input logic [DW-1:0] x, input logic [CW-1:0] n);
        logic [2*DW-1:0] d;
        d = {x, x} << n;
        return d[2*DW-1:DW];
    endfunction : rotl

    // Byte-lane write merge
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
        input logic [DW-1:0] nw, input logic [3:0] sel);
        logic [DW-1:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

endpackage : rsm_pkg

/* File: core/rot_shift_mask.sv */
// Purpose: Rotate, mask and shift datapath behind a Wishbone register file.
// Assumes: Classic Wishbone single cycles, word-aligned addresses.
// Notes: An operation runs one cycle after its control or opcode write.
`timescale 1ns/100ps
module rot_shift_mask
    import rsm_pkg::*;
(
    input wire logic clk,              // 100 MHz clock
    input wire logic resetn,           // Async reset, active low
    input wire logic wb_cyc_i,         // Bus cycle
    input wire logic wb_stb_i,         // Strobe
    input wire logic wb_we_i,          // Write enable
    input wire logic [AW-1:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i,   // Byte lanes
    input wire logic [DW-1:0] wb_dat_i, // Write data
    output logic [DW-1:0] wb_dat_o,    // Read data
    output logic wb_ack_o              // Acknowledge
);

    // ==========================================================
    // Reset release
    logic rst_meta_r;
    logic rst_n;

    // Two-stage release of reset
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // ==========================================================
    // Bus decode
    logic ack_r;
    logic [DW-1:0] rdat_r;
    logic req;
    logic wr;
    logic [DW-1:0] src_r;
    logic [DW-1:0] amt_r;
    logic [DW-1:0] dest_r;
    ctrl_t ctrl_r;
    logic [3:0] cond_r;
    logic so_r;
    logic borrow_r;
    logic go_r;
    logic insn_hit;

    // New request not yet answered
    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr = req && wb_we_i;
    // Opcode register write that names the arithmetic shift
    assign insn_hit = wr && wb_adr_i == OFF_INSN && wb_sel_i == SEL_ALL
        && wb_dat_i[INSN_PRI_LSB +: 6] == PRI_SRA
        && wb_dat_i[INSN_EXT_LSB +: 10] == EXT_SRA;

    // Acknowledge one cycle after the request
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_r <= 1'b0;
        end
        else
        begin
            ack_r <= req;
        end
    end

    // Read data mux, unmapped reads as zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdat_r <= ZERO;
        end
        else if (req && !wb_we_i)
        begin
            unique case (wb_adr_i)
                OFF_SRC: rdat_r <= src_r;
                OFF_AMT: rdat_r <= amt_r;
                OFF_DEST: rdat_r <= dest_r;
                OFF_CTRL: rdat_r <= ctrl_r;
                OFF_COND: rdat_r <= {28'h0000000, cond_r};
                OFF_EXC:
                begin
                    rdat_r <= ZERO;
                    rdat_r[EXC_SO] <= so_r;
                    rdat_r[EXC_BORROW] <= borrow_r;
                end
                default: rdat_r <= ZERO;
            endcase
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // ==========================================================
    // Operand registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            src_r <= ZERO;
            amt_r <= ZERO;
        end
        else if (wr)
        begin
            if (wb_adr_i == OFF_SRC)
            begin
                src_r <= merge(src_r, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == OFF_AMT)
            begin
                amt_r <= merge(amt_r, wb_dat_i, wb_sel_i);
            end
        end
    end

    // Control word and launch pulse
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r <= '0;
            go_r <= 1'b0;
        end
        else
        begin
            go_r <= 1'b0;
            if (wr && wb_adr_i == OFF_CTRL)
            begin
                ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i);
                go_r <= 1'b1;
            end
            else if (insn_hit)
            begin
                ctrl_r.op <= OP_SRA;
                ctrl_r.record_flag <= wb_dat_i[INSN_RECORD];
                go_r <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Datapath
    logic [DW-1:0] mask;
    logic [DW-1:0] m_from;
    logic [DW-1:0] m_to;
    logic [CW-1:0] rot_n;
    logic [CW-1:0] rot_eff;
    logic [DW-1:0] rot;
    logic [CW-1:0] shift_n;
    logic big;
    logic sgn;
    logic [DW-1:0] lost;
    logic [DW-1:0] result;
    logic borrow_nxt;
    logic op_ok;

    assign shift_n = amt_r[CW-1:0];
    assign big = amt_r[AMT_BIG];
    assign sgn = src_r[DW-1];

    // Mask from big-endian begin and end positions
    always_comb
    begin
        m_from = ONES >> ctrl_r.mask_begin;
        m_to = ~((ONES >> ctrl_r.mask_end) >> 1);
        if (ctrl_r.mask_begin <= ctrl_r.mask_end)
        begin
            mask = m_from & m_to;
        end
        else
        begin
            mask = m_from | m_to;
        end
    end

    // Rotate count, right rotate as left by 32 minus n
    always_comb
    begin
        rot_n = ctrl_r.rotate_amount;
        if (op_t'(ctrl_r.op) == OP_AND_REG)
        begin
            rot_n = shift_n;
        end
        rot_eff = ctrl_r.rot_right ? CW'(~rot_n + 5'h01) : rot_n;
        rot = rotl(src_r, rot_eff);
    end

    // Result selection and borrow
    always_comb
    begin
        result = dest_r;
        op_ok = 1'b1;
        lost = big ? src_r : (src_r & ~(ONES << shift_n));
        borrow_nxt = sgn && (|lost);
        unique case (op_t'(ctrl_r.op))
            OP_INSERT: result = (rot & mask) | (dest_r & ~mask);
            OP_AND_IMM: result = rot & mask;
            OP_AND_REG: result = rot & mask;
            OP_SHL: result = big ? ZERO : (src_r << shift_n);
            OP_SRA: result = big ? {DW{sgn}}
                : DW'($signed(src_r) >>> shift_n);
            default: op_ok = 1'b0;
        endcase
    end

    // ==========================================================
    // Result and flag registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dest_r <= ZERO;
        end
        else if (go_r && op_ok)
        begin
            dest_r <= result;
        end
        else if (wr && wb_adr_i == OFF_DEST)
        begin
            dest_r <= merge(dest_r, wb_dat_i, wb_sel_i);
        end
    end

    // Exception register: borrow and summary overflow
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            so_r <= 1'b0;
            borrow_r <= 1'b0;
        end
        else if (go_r && op_t'(ctrl_r.op) == OP_SRA)
        begin
            borrow_r <= borrow_nxt;
        end
        else if (wr && wb_adr_i == OFF_EXC && wb_sel_i[3])
        begin
            so_r <= wb_dat_i[EXC_SO];
            borrow_r <= wb_dat_i[EXC_BORROW];
        end
    end

    // Condition field from the written value
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cond_r <= 4'h0;
        end
        else if (go_r && op_ok && ctrl_r.record_flag)
        begin
            cond_r[COND_LESS] <= result[DW-1];
            cond_r[COND_GREATER] <= !result[DW-1] && (|result);
            cond_r[COND_EQUAL] <= result == ZERO;
            cond_r[COND_SO] <= so_r;
        end
    end

    // ==========================================================
    // Checks
    mask_ends_a: assert property (@(posedge clk) disable iff (!rst_n)
        mask[~ctrl_r.mask_begin] && mask[~ctrl_r.mask_end])
        else $error("mask end bits not set");
    insert_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        go_r && op_t'(ctrl_r.op) == OP_INSERT
        |=> ((dest_r ^ $past(dest_r)) & ~$past(mask)) == ZERO)
        else $error("insert changed unmasked bits");
    and_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
        go_r && op_t'(ctrl_r.op) == OP_AND_IMM
        |=> (dest_r & ~$past(mask)) == ZERO)
        else $error("and result outside mask");
    reg_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        go_r && op_t'(ctrl_r.op) == OP_AND_REG && !ctrl_r.rot_right
        |=> dest_r == (rotl($past(src_r), $past(shift_n)) & $past(mask)))
        else $error("register rotate count wrong");
    cond_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
        go_r && op_ok && ctrl_r.record_flag
        |=> cond_r[COND_EQUAL] == (dest_r == ZERO) && cond_r[COND_LESS] == dest_r[DW-1])
        else $error("condition field mismatch");
    shl_value_a: assert property (@(posedge clk) disable iff (!rst_n)
        go_r && op_t'(ctrl_r.op) == OP_SHL && !big
        |=> dest_r == ($past(src_r) << $past(shift_n)))
        else $error("left shift value wrong");
    shl_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        go_r && op_t'(ctrl_r.op) == OP_SHL && big |=> dest_r == ZERO)
        else $error("big left shift not zero");
    sra_sign_a: assert property (@(posedge clk) disable iff (!rst_n)
        go_r && op_t'(ctrl_r.op) == OP_SRA && !big
        |=> dest_r[DW-1] == $past(sgn))
        else $error("right shift lost sign");
    sra_big_a: assert property (@(posedge clk) disable iff (!rst_n)
        go_r && op_t'(ctrl_r.op) == OP_SRA && big
        |=> dest_r == {DW{$past(sgn)}})
        else $error("big right shift not sign fill");
    borrow_pos_a: assert property (@(posedge clk) disable iff (!rst_n)
        go_r && op_t'(ctrl_r.op) == OP_SRA && !sgn |=> !borrow_r)
        else $error("borrow set for positive source");
    borrow_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        go_r && op_t'(ctrl_r.op) == OP_SRA && amt_r[AMT_BIG:0] == 6'h00 |=> !borrow_r)
        else $error("borrow set for zero count");
    insn_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
        insn_hit |=> go_r && op_t'(ctrl_r.op) == OP_SRA
        && ctrl_r.record_flag == $past(wb_dat_i[INSN_RECORD]))
        else $error("shift opcode not decoded");

endmodule : rot_shift_mask

/* File: dv/test_rot_shift_mask.sv */
// Purpose: Self-checking bench of the rotate/shift/mask unit over Wishbone.
// Assumes: One-cycle ack, launch result visible to the next read.
// Notes: A bench model keeps source, count, result, exception and condition and is compared at each result read.
`timescale 1ns/100ps
module test_rot_shift_mask
    import rsm_pkg::*;
;
    // ==========================================================
    // Clock, reset and bus signals
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [AW-1:0] adr = 5'h00;
    logic [3:0] sel = 4'h0;
    logic [DW-1:0] dat = 32'h00000000;
    logic [DW-1:0] wb_dat_o;
    logic wb_ack_o;
    int num_errors = 0;
    int checked = 0;
    logic [DW-1:0] m_src, m_amt, m_dest, m_exc, q;
    logic [3:0] m_cond;

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    rot_shift_mask rot_shift_mask_inst (
        .clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o)
    );

    // ==========================================================
    // Verdict, comparison and bus tasks
    task automatic complete_run();
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One classic cycle, held until ack is seen high at a rising edge
    task automatic wb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d,
        input logic [3:0] s);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        for (k = 0; k < 20; k++)
        begin
            @(posedge clk);
            if (wb_ack_o === 1'b1)
                break;
        end
        if (k == 20)
        begin
            num_errors++;
            complete_run();
        end
        // Read data taken and request released at the ack edge
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        wb(1'b1, a, d, SEL_ALL);
    endtask : wr

    task automatic rd(input logic [AW-1:0] a);
        wb(1'b0, a, 32'h00000000, SEL_ALL);
    endtask : rd

    // ==========================================================
    // Behavioural model of one launch
    task automatic model_op(input logic [DW-1:0] c);
        logic [DW-1:0] m, r, res;
        int n, mb, me, op;
        op = c[2:0];
        n = c[7:3];
        mb = c[12:8];
        me = c[17:13];
        if (op == 2)
            n = m_amt[4:0];
        if (c[19])
            n = (32 - n) % 32;
        r = (m_src << n) | (m_src >> (32 - n));
        for (int i = 0; i < 32; i++)
            m[31-i] = (mb <= me) ? (i >= mb && i <= me) : (i >= mb || i <= me);
        res = m_dest;
        if (op == 0)
            res = (r & m) | (m_dest & ~m);
        if (op == 1 || op == 2)
            res = r & m;
        if (op == 3)
            res = m_amt[5] ? 32'h00000000 : m_src << m_amt[4:0];
        if (op == 4)
        begin
            res = $signed(m_src) >>> m_amt[4:0];
            if (m_amt[5])
                res = {32{m_src[31]}};
            m_exc[29] = m_src[31] & (m_amt[5] |
                ((m_src & ((32'h1 << m_amt[4:0]) - 1)) != 0));
        end
        if (c[18] && op < 5)
            m_cond = {$signed(res) < 0, $signed(res) > 0, res == 0, m_exc[31]};
        m_dest = res;
    endtask : model_op

    // Compare result registers with the model
    task automatic check_results();
        rd(OFF_DEST);
        check(q, m_dest);
        rd(OFF_COND);
        check(q, {28'h0000000, m_cond});
        rd(OFF_EXC);
        check(q, m_exc);
    endtask : check_results

    // ==========================================================
    // Main sequence
    initial
    begin
        logic [DW-1:0] c, w;
        void'($urandom(59447));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        // Reset values, unmapped place included
        for (int a = 0; a < 32; a += 4)
        begin
            rd(a[4:0]);
            check(q, 32'h00000000);
        end
        {m_src, m_amt, m_dest, m_exc, m_cond} = '0;
        $display("test reset_values done");
        // Random launches of every operation code
        for (int i = 0; i < 64; i++)
        begin
            m_src = $urandom();
            m_amt = $urandom() & 32'h0000003f;
            // Zero count bits 4:0 on every other shift-right launch only
            if (i % 16 == 4)
                m_amt[4:0] = 5'h00;
            m_dest = $urandom();
            m_exc = $urandom() & 32'ha0000000;
            c = $urandom();
            c[2:0] = 3'(i % 8);
            if (c[2:0] > 2)
                c[19] = 1'b0;
            wr(OFF_SRC, m_src);
            wr(OFF_AMT, m_amt);
            wr(OFF_DEST, m_dest);
            wr(OFF_EXC, m_exc);
            wr(OFF_CTRL, c);
            model_op(c);
            check_results();
            rd(OFF_CTRL);
            check(q, c);
        end
        $display("test random_ops done");
        // Opcode launch of the arithmetic shift, then a foreign opcode
        for (int i = 0; i < 8; i++)
        begin
            w = {6'h1f, 15'($urandom()), 10'h318, 1'(i)};
            if (i > 5)
                w[10:1] = 10'h338;
            m_src = $urandom() | 32'h80000000;
            m_amt = (i == 2) ? 32'h00000000 : $urandom() & 32'h0000003f;
            wr(OFF_SRC, m_src);
            wr(OFF_AMT, m_amt);
            wr(OFF_INSN, w);
            if (i <= 5)
                model_op({13'h0000, w[0], 15'h0000, 3'h4});
            check_results();
            rd(OFF_INSN);
            check(q, 32'h00000000);
        end
        $display("test opcode_launch done");
        // Byte lanes and unmapped write
        wr(OFF_SRC, 32'h11223344);
        wb(1'b1, OFF_SRC, 32'haabbccdd, 4'h5);
        rd(OFF_SRC);
        check(q, 32'h11bb33dd);
        wr(5'h1c, 32'hffffffff);
        rd(5'h1c);
        check(q, 32'h00000000);
        $display("test lanes_unmapped done");
        complete_run();
    end
endmodule : test_rot_shift_mask
